// ==== rtl/amd_datapath.sv ====
// execution datapath: timer moves, indirect moves, exchange, save/restore, add and subtract
module amd_datapath
   import amd_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic op_start,
   input wire amd_op_t op_code,
   input wire logic [7:0] op_addr,
   input wire logic [7:0] op_imm,
   input wire logic [15:0] timer_count,
   input wire logic [7:0] mem_rdata,
   output logic busy,
   output logic done,
   output logic [7:0] mem_addr,
   output logic mem_rd,
   output logic mem_wr,
   output logic [7:0] mem_wdata,
   output logic timer_load,
   output logic [15:0] timer_load_value,
   output logic [7:0] working_register,
   output logic [3:0] flags,
   output logic [7:0] stack_pointer
);

   typedef struct packed {
      amd_state_t st;
      logic busy;
      logic done;
      amd_op_t op;
      logic [7:0] addr;
      logic [7:0] tmp;
      logic [15:0] cnt;
      logic [7:0] acc;
      logic [3:0] flg;
      logic [7:0] sp;
      logic [7:0] mem_addr;
      logic mem_rd;
      logic mem_wr;
      logic [7:0] mem_wdata;
      logic t_load;
      logic [15:0] t_val;
   } amd_regs_t;

   amd_regs_t r_q;
   amd_regs_t r_d;
   amd_op_t cur_op;
   logic [7:0] src;
   logic [7:0] ax;
   logic [7:0] ay;
   logic acin;
   logic [11:0] alu_o;

   // flags as {ov, ac, c, z} in their field positions, result in the low byte
   function automatic logic [11:0] alu(input logic [7:0] x, input logic [7:0] y, input logic ci);
      logic [8:0] s;
      logic [4:0] h;
      logic [3:0] f;
      s = {1'b0, x} + {1'b0, y} + {8'h00, ci};
      h = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
      f = 4'h0;
      f[FLG_Z] = (s[7:0] == 8'h00);
      f[FLG_C] = s[8];
      f[FLG_AC] = h[4];
      f[FLG_OV] = (x[7] == y[7]) && (s[7] != x[7]);
      return {f, s[7:0]};
   endfunction

   always_comb
   begin
      r_d = r_q;
      r_d.done = 1'b0;
      r_d.mem_rd = 1'b0;
      r_d.mem_wr = 1'b0;
      r_d.t_load = 1'b0;
      // immediate ops run from idle, memory ops once the byte is back
      cur_op = (r_q.st == ST_IDLE) ? op_code : r_q.op;
      src = (r_q.st == ST_IDLE) ? op_imm : mem_rdata;
      ax = r_q.acc;
      ay = src;
      acin = 1'b0;
      case (cur_op)
         OP_ADDC_AM, OP_ADDC_MA: acin = r_q.flg[FLG_C];
         OP_ADDC_A:
         begin
            ay = 8'h00;
            acin = r_q.flg[FLG_C];
         end
         OP_ADDC_M:
         begin
            ax = src;
            ay = 8'h00;
            acin = r_q.flg[FLG_C];
         end
         OP_NADD_AM:
         begin
            ax = src;
            ay = ~r_q.acc;
            acin = 1'b1;
         end
         OP_NADD_MA, OP_SUB_AM, OP_SUB_AI:
         begin
            ay = ~src;
            acin = 1'b1;
         end
         default: acin = 1'b0;
      endcase
      alu_o = alu(ax, ay, acin);
      case (r_q.st)
         ST_IDLE:
         begin
            if (op_start)
            begin
               r_d.op = op_code;
               r_d.addr = op_addr;
               r_d.cnt = timer_count;
               r_d.busy = 1'b1;
               case (op_code)
                  OP_ADD_AI, OP_SUB_AI, OP_ADDC_A:
                  begin
                     r_d.acc = alu_o[7:0];
                     r_d.flg = alu_o[11:8];
                     r_d.busy = 1'b0;
                     r_d.done = 1'b1;
                  end
                  OP_TRD:
                  begin
                     // count is latched so both bytes come from one sample
                     r_d.mem_wr = 1'b1;
                     r_d.mem_addr = op_addr;
                     r_d.mem_wdata = timer_count[7:0];
                     r_d.st = ST_WR1;
                  end
                  OP_PUSH:
                  begin
                     r_d.mem_wr = 1'b1;
                     r_d.mem_addr = r_q.sp;
                     r_d.mem_wdata = r_q.acc;
                     r_d.st = ST_WR1;
                  end
                  OP_POP:
                  begin
                     r_d.sp = r_q.sp - SP_STEP;
                     r_d.mem_rd = 1'b1;
                     r_d.mem_addr = r_q.sp - SP_STEP;
                     r_d.st = ST_RD0;
                  end
                  OP_TWR, OP_IRD, OP_IWR, OP_XCH, OP_ADD_AM, OP_ADD_MA, OP_ADDC_AM, OP_ADDC_MA,
                  OP_ADDC_M, OP_NADD_AM, OP_NADD_MA, OP_SUB_AM:
                  begin
                     r_d.mem_rd = 1'b1;
                     r_d.mem_addr = op_addr;
                     r_d.st = ST_RD0;
                  end
                  default:
                  begin
                     r_d.busy = 1'b0;
                     r_d.done = 1'b1;
                  end
               endcase
            end
         end
         ST_RD0:
         begin
            r_d.st = ST_IDLE;
            r_d.busy = 1'b0;
            r_d.done = 1'b1;
            case (r_q.op)
               OP_ADD_AM, OP_ADDC_AM, OP_NADD_AM, OP_SUB_AM:
               begin
                  r_d.acc = alu_o[7:0];
                  r_d.flg = alu_o[11:8];
               end
               OP_ADD_MA, OP_ADDC_MA, OP_ADDC_M, OP_NADD_MA:
               begin
                  r_d.flg = alu_o[11:8];
                  r_d.mem_wr = 1'b1;
                  r_d.mem_addr = r_q.addr;
                  r_d.mem_wdata = alu_o[7:0];
               end
               OP_XCH:
               begin
                  r_d.mem_wr = 1'b1;
                  r_d.mem_addr = r_q.addr;
                  r_d.mem_wdata = r_q.acc;
                  r_d.acc = mem_rdata;
               end
               OP_TWR:
               begin
                  r_d.tmp = mem_rdata;
                  r_d.mem_rd = 1'b1;
                  r_d.mem_addr = r_q.addr + BYTE_STEP;
                  r_d.st = ST_RD1;
                  r_d.busy = 1'b1;
                  r_d.done = 1'b0;
               end
               OP_IRD:
               begin
                  // only the pointer's low byte is fetched; the high byte is left to software
                  r_d.mem_rd = 1'b1;
                  r_d.mem_addr = mem_rdata;
                  r_d.st = ST_RD1;
                  r_d.busy = 1'b1;
                  r_d.done = 1'b0;
               end
               OP_IWR:
               begin
                  r_d.mem_wr = 1'b1;
                  r_d.mem_addr = mem_rdata;
                  r_d.mem_wdata = r_q.acc;
               end
               OP_POP:
               begin
                  r_d.acc = mem_rdata;
                  r_d.mem_rd = 1'b1;
                  r_d.mem_addr = r_q.sp + BYTE_STEP;
                  r_d.st = ST_RD1;
                  r_d.busy = 1'b1;
                  r_d.done = 1'b0;
               end
               default: r_d.acc = r_q.acc;
            endcase
         end
         ST_RD1:
         begin
            r_d.st = ST_IDLE;
            r_d.busy = 1'b0;
            r_d.done = 1'b1;
            case (r_q.op)
               OP_TWR:
               begin
                  r_d.t_load = 1'b1;
                  r_d.t_val = {mem_rdata, r_q.tmp};
               end
               OP_IRD: r_d.acc = mem_rdata;
               OP_POP: r_d.flg = mem_rdata[FLG_W-1:0];
               default: r_d.acc = r_q.acc;
            endcase
         end
         ST_WR1:
         begin
            r_d.st = ST_IDLE;
            r_d.busy = 1'b0;
            r_d.done = 1'b1;
            r_d.mem_wr = 1'b1;
            if (r_q.op == OP_PUSH)
            begin
               r_d.mem_addr = r_q.sp + BYTE_STEP;
               r_d.mem_wdata = {4'h0, r_q.flg};
               r_d.sp = r_q.sp + SP_STEP;
            end
            else
            begin
               r_d.mem_addr = r_q.addr + BYTE_STEP;
               r_d.mem_wdata = r_q.cnt[15:8];
            end
         end
         default: r_d.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         r_q <= '0;
         r_q.st <= ST_IDLE;
         r_q.op <= OP_TRD;
         r_q.acc <= ACC_RST;
         r_q.flg <= FLG_RST;
         r_q.sp <= SP_RST;
      end
      else
      begin
         r_q <= r_d;
      end
   end

   assign busy = r_q.busy;
   assign done = r_q.done;
   assign mem_addr = r_q.mem_addr;
   assign mem_rd = r_q.mem_rd;
   assign mem_wr = r_q.mem_wr;
   assign mem_wdata = r_q.mem_wdata;
   assign timer_load = r_q.t_load;
   assign timer_load_value = r_q.t_val;
   assign working_register = r_q.acc;
   assign flags = r_q.flg;
   assign stack_pointer = r_q.sp;

   // checks on the sequences above
   logic accept;
   logic [7:0] cnt_lo;
   logic [7:0] cnt_hi;
   logic [3:0] rd_flg;
   assign accept = op_start && (r_q.st == ST_IDLE);
   assign cnt_lo = timer_count[7:0];
   assign cnt_hi = timer_count[15:8];
   assign rd_flg = mem_rdata[3:0];

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_rd_then_rd;
      mem_rd ##1 (mem_rd && mem_addr == $past(mem_rdata));
   endsequence
   sequence s_two_writes;
      mem_wr ##1 (mem_wr && mem_addr == 8'($past(mem_addr) + BYTE_STEP));
   endsequence

   timer_rd_a: assert property ((accept && op_code == OP_TRD) |=> (s_two_writes and
      ((mem_wdata == $past(cnt_lo)) ##1 (mem_wdata == $past(cnt_hi, 2) && $stable(flags)))))
      else $error("timer read bytes or flags wrong");
   timer_wr_a: assert property ((accept && op_code == OP_TWR) |=> mem_rd ##1 mem_rd ##1
      (timer_load && timer_load_value[15:8] == $past(mem_rdata) && flags == $past(flags, 3)))
      else $error("timer write load wrong");
   ind_rd_a: assert property ((accept && op_code == OP_IRD) |=> s_rd_then_rd ##1
      (working_register == $past(mem_rdata) && done))
      else $error("indirect read wrong");
   ind_wr_a: assert property ((accept && op_code == OP_IWR) |=> mem_rd ##1
      (mem_wr && mem_addr == $past(mem_rdata) && mem_wdata == working_register))
      else $error("indirect write wrong");
   xch_swap_a: assert property ((accept && op_code == OP_XCH) |=> mem_rd ##1
      (mem_wr && mem_wdata == $past(working_register) && working_register == $past(mem_rdata) && $stable(flags)))
      else $error("exchange wrong");
   push_pair_a: assert property ((accept && op_code == OP_PUSH) |=> s_two_writes and
      ((mem_addr == $past(stack_pointer) && mem_wdata == $past(working_register)) ##1
      (mem_wdata == {4'h0, flags} && stack_pointer == 8'($past(stack_pointer, 2) + SP_STEP))))
      else $error("save wrong");
   pop_pair_a: assert property ((accept && op_code == OP_POP) |=>
      (mem_rd && mem_addr == 8'($past(stack_pointer) - SP_STEP)) ##1 mem_rd ##1
      (flags == $past(rd_flg) && working_register == $past(mem_rdata, 2)))
      else $error("restore wrong");
   add_imm_a: assert property ((accept && op_code == OP_ADD_AI) |=>
      (done && working_register == 8'($past(working_register) + $past(op_imm)) &&
      flags[FLG_Z] == (working_register == 8'h00)))
      else $error("add immediate wrong");
   sub_imm_a: assert property ((accept && op_code == OP_SUB_AI) |=>
      (working_register == 8'($past(working_register) - $past(op_imm)) &&
      flags[FLG_C] == ($past(working_register) >= $past(op_imm))))
      else $error("subtract immediate wrong");
endmodule

// ==== rtl/amd_pkg.sv ====
// constants and types shared by the accumulator move and arithmetic datapath
// Summary of operation
// - timer read stores count to word, flags kept
// - timer write loads count from word, flags kept
// - indirect read loads working register via pointer
// - indirect write stores working register via pointer
// - exchange swaps working register and memory byte
// - save writes register and flags, pointer plus two
// - restore: pointer minus two, reload register, flags
// - add immediate into working register, flags updated
// - add register and memory, operand-selected destination
// - add with carry, operand-selected destination
// - add carry alone to register or memory
// - memory minus register into working register
// - register minus memory into memory
// - subtract immediate from working register
// - subtract memory from working register
package amd_pkg;
   localparam int DATA_W = 8;
   localparam int FLG_W = 4;
   localparam int CNT_W = 16;
   localparam int FLG_Z = 0;
   localparam int FLG_C = 1;
   localparam int FLG_AC = 2;
   localparam int FLG_OV = 3;
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [3:0] FLG_RST = 4'h0;
   localparam logic [7:0] SP_RST = 8'h00;
   localparam logic [7:0] SP_STEP = 8'h02;
   localparam logic [7:0] BYTE_STEP = 8'h01;

   typedef enum logic [4:0] {
      OP_TRD     = 5'b00000,
      OP_TWR     = 5'b00001,
      OP_IRD     = 5'b00010,
      OP_IWR     = 5'b00011,
      OP_XCH     = 5'b00100,
      OP_PUSH    = 5'b00101,
      OP_POP     = 5'b00110,
      OP_ADD_AI  = 5'b00111,
      OP_ADD_AM  = 5'b01000,
      OP_ADD_MA  = 5'b01001,
      OP_ADDC_AM = 5'b01010,
      OP_ADDC_MA = 5'b01011,
      OP_ADDC_A  = 5'b01100,
      OP_ADDC_M  = 5'b01101,
      OP_NADD_AM = 5'b01110,
      OP_NADD_MA = 5'b01111,
      OP_SUB_AI  = 5'b10000,
      OP_SUB_AM  = 5'b10001
   } amd_op_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RD0  = 2'b01,
      ST_RD1  = 2'b10,
      ST_WR1  = 2'b11
   } amd_state_t;
endpackage

// ==== testbench/amd_datapath_test.sv ====
// self-checking bench for the accumulator move and arithmetic datapath
module amd_datapath_test;
   import amd_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk;
   logic sys_rst;
   logic op_start;
   amd_op_t op_code;
   logic [7:0] op_addr, op_imm, mem_rdata, mem_addr, mem_wdata, working_register, stack_pointer;
   logic [15:0] timer_count, timer_load_value, t_val;
   logic busy, done, mem_rd, mem_wr, timer_load;
   logic [3:0] flags;
   logic [7:0] mem [256];
   logic [7:0] m_acc, sa0, sa1;
   logic [3:0] m_flg, sf0, sf1;
   // busy as seen half a cycle after the accepting edge, for multi-cycle ops
   logic busy_seen;
   int error_cnt = 0;
   int tests_run = 0;

   amd_datapath i_amd_datapath (
      .clk(clk), .sys_rst(sys_rst), .op_start(op_start), .op_code(op_code), .op_addr(op_addr),
      .op_imm(op_imm), .timer_count(timer_count), .mem_rdata(mem_rdata), .busy(busy), .done(done),
      .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
      .timer_load(timer_load), .timer_load_value(timer_load_value),
      .working_register(working_register), .flags(flags), .stack_pointer(stack_pointer));

   // idle read bus shows inverted data so a stale byte cannot pass for a real read
   assign mem_rdata = mem_rd ? mem[mem_addr] : ~mem[mem_addr];

   always @(posedge clk)
   begin
      if (mem_wr === 1'b1)
         mem[mem_addr] <= mem_wdata;
      if (timer_load === 1'b1)
         t_val <= timer_load_value;
   end

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic close_out();
      $display("errors %0d checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      chk16({8'h00, got}, {8'h00, exp});
   endtask

   // expected sum as {ov, half carry, carry, zero, result}
   function automatic logic [11:0] alu(input logic [7:0] a, input logic [7:0] b, input logic ci);
      logic [8:0] s;
      logic [4:0] h;
      logic ov;
      s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
      h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
      ov = (a[7] == b[7]) && (s[7] != a[7]);
      return {ov, h[4], s[8], s[7:0] == 8'h00, s[7:0]};
   endfunction

   task automatic run_op(input amd_op_t op, input logic [7:0] addr, input logic [7:0] imm);
      int n;
      @(negedge clk);
      op_start = 1'b1;
      op_code = op;
      op_addr = addr;
      op_imm = imm;
      @(negedge clk);
      op_start = 1'b0;
      busy_seen = busy;
      n = 0;
      while (done !== 1'b1 && n < 8)
      begin
         @(negedge clk);
         n++;
      end
      if (n == 8)
      begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, done, 1'b1);
         close_out();
      end
      // one more edge lets a memory write of the done cycle land
      @(negedge clk);
   endtask

   task automatic arith(input amd_op_t op, input logic [7:0] addr, input logic [7:0] imm);
      logic [7:0] m;
      logic [11:0] r;
      logic ci;
      logic to_m;
      m = mem[addr];
      ci = m_flg[FLG_C];
      to_m = op inside {OP_ADD_MA, OP_ADDC_MA, OP_ADDC_M, OP_NADD_MA};
      case (op)
         OP_ADD_AI: r = alu(m_acc, imm, 1'b0);
         OP_ADD_AM, OP_ADD_MA: r = alu(m_acc, m, 1'b0);
         OP_ADDC_AM, OP_ADDC_MA: r = alu(m_acc, m, ci);
         OP_ADDC_A: r = alu(m_acc, 8'h00, ci);
         OP_ADDC_M: r = alu(m, 8'h00, ci);
         OP_NADD_AM: r = alu(m, ~m_acc, 1'b1);
         OP_NADD_MA: r = alu(m_acc, ~m, 1'b1);
         OP_SUB_AI: r = alu(m_acc, ~imm, 1'b1);
         default: r = alu(m_acc, ~m, 1'b1);
      endcase
      run_op(op, addr, imm);
      m_flg = r[11:8];
      if (to_m)
         m = r[7:0];
      else
         m_acc = r[7:0];
      chk8(working_register, m_acc);
      chk8({4'h0, flags}, {4'h0, m_flg});
      chk8(mem[addr], m);
   endtask

   initial
   begin
      sys_rst = 1'b1;
      op_start = 1'b0;
      op_code = OP_TRD;
      op_addr = 8'h00;
      op_imm = 8'h00;
      timer_count = 16'hbeef;
      t_val = 16'h0000;
      m_acc = 8'h00;
      m_flg = 4'h0;
      for (int i = 0; i < 256; i++)
         mem[i] = 8'(i) ^ 8'h5a;
      mem[8'h11] = 8'hff;
      mem[8'h13] = 8'h80;
      mem[8'h14] = 8'hff;
      repeat (16) @(posedge clk);
      @(negedge clk);
      sys_rst = 1'b0;
      chk8(working_register, 8'h00);
      chk8(stack_pointer, 8'h00);
      arith(OP_ADD_AI, 8'h00, 8'h7f);
      arith(OP_ADD_AI, 8'h00, 8'h01);
      arith(OP_ADD_AI, 8'h00, 8'h80);
      arith(OP_ADDC_A, 8'h00, 8'h00);
      arith(OP_ADD_AM, 8'h10, 8'h00);
      arith(OP_ADD_MA, 8'h11, 8'h00);
      arith(OP_ADDC_AM, 8'h12, 8'h00);
      arith(OP_ADDC_MA, 8'h13, 8'h00);
      arith(OP_ADDC_M, 8'h14, 8'h00);
      arith(OP_NADD_AM, 8'h15, 8'h00);
      arith(OP_NADD_MA, 8'h16, 8'h00);
      arith(OP_SUB_AI, 8'h00, 8'h0f);
      arith(OP_SUB_AM, 8'h17, 8'h00);
      run_op(OP_TRD, 8'h20, 8'h00);
      chk16({mem[8'h21], mem[8'h20]}, 16'hbeef);
      chk8({4'h0, flags}, {4'h0, m_flg});
      mem[8'h30] = 8'h34;
      mem[8'h31] = 8'h12;
      run_op(OP_TWR, 8'h30, 8'h00);
      chk16(t_val, 16'h1234);
      chk8({4'h0, flags}, {4'h0, m_flg});
      mem[8'h40] = 8'h5b;
      mem[8'h41] = 8'h00;
      mem[8'h5b] = 8'ha5;
      run_op(OP_IRD, 8'h40, 8'h00);
      chk8({7'h00, busy_seen}, 8'h01);
      chk8({7'h00, busy}, 8'h00);
      m_acc = 8'ha5;
      chk8(working_register, m_acc);
      chk8({4'h0, flags}, {4'h0, m_flg});
      mem[8'h42] = 8'h6c;
      mem[8'h43] = 8'h00;
      arith(OP_ADD_AI, 8'h00, 8'h11);
      run_op(OP_IWR, 8'h42, 8'h00);
      chk8(mem[8'h6c], m_acc);
      chk8({4'h0, flags}, {4'h0, m_flg});
      mem[8'h50] = 8'h3c;
      sa0 = m_acc;
      run_op(OP_XCH, 8'h50, 8'h00);
      m_acc = 8'h3c;
      chk8(working_register, m_acc);
      chk8(mem[8'h50], sa0);
      chk8({4'h0, flags}, {4'h0, m_flg});
      sa0 = m_acc;
      sf0 = m_flg;
      run_op(OP_PUSH, 8'h00, 8'h00);
      chk8(mem[8'h00], sa0);
      chk8(mem[8'h01], {4'h0, sf0});
      chk8(stack_pointer, 8'h02);
      arith(OP_ADD_AI, 8'h00, 8'hc4);
      sa1 = m_acc;
      sf1 = m_flg;
      run_op(OP_PUSH, 8'h00, 8'h00);
      chk8(mem[8'h02], sa1);
      chk8(mem[8'h03], {4'h0, sf1});
      chk8(stack_pointer, 8'h04);
      arith(OP_SUB_AI, 8'h00, 8'hd0);
      run_op(OP_POP, 8'h00, 8'h00);
      chk8(working_register, sa1);
      chk8({4'h0, flags}, {4'h0, sf1});
      chk8(stack_pointer, 8'h02);
      m_acc = sa1;
      m_flg = sf1;
      arith(OP_SUB_AM, 8'h18, 8'h00);
      run_op(OP_POP, 8'h00, 8'h00);
      chk8(working_register, sa0);
      chk8({4'h0, flags}, {4'h0, sf0});
      chk8(stack_pointer, 8'h00);
      close_out();
   end
endmodule
